// >>> verilog/lcc_pkg.sv
// Package for the ladder converter control block: register map, fields, codes, carriers.
// Assumes an APB slave at 25 MHz and two converter instances behind it.
// Contract
// - Converter works only while its enable bit (bit 7) is set.
// - First instance: pin code 10 routes to pin two, 01 to pin zero.
// - At most one output pin connected at any time, whatever code.
// - Upper reference: 00 supply, 01 external pin, 10 fixed buffer; 11 reserved.
// - Lower reference bit 0: 1 external negative pin, 0 ground.
// - Eight-bit level code picks one of 256 ladder taps.
// - Device reset disables converter and disconnects all output pins.
// - Device reset clears level code and control fields to zero.
// - Wake from sleep leaves control and level registers unchanged.
// - In sleep the converter reference is switched off.
// - Second instance has no output pin select and no output buffer.
// - Registers decode at 0x7D, 0x7F, 0xA0, 0xA2 (register indexes).
package lcc_pkg;

  // ==========================================================
  // Register map (printed offsets are indexes, byte address is four times)
  localparam logic [7:0]  LCC_IDX_LEVEL_ONE = 8'h7D;
  localparam logic [7:0]  LCC_IDX_CTL_ONE   = 8'h7F;
  localparam logic [7:0]  LCC_IDX_LEVEL_TWO = 8'hA0;
  localparam logic [7:0]  LCC_IDX_CTL_TWO   = 8'hA2;
  localparam int          LCC_AW            = 12;
  localparam logic [11:0] LCC_ADDR_LEVEL_ONE = {2'h0, LCC_IDX_LEVEL_ONE, 2'h0};
  localparam logic [11:0] LCC_ADDR_CTL_ONE   = {2'h0, LCC_IDX_CTL_ONE, 2'h0};
  localparam logic [11:0] LCC_ADDR_LEVEL_TWO = {2'h0, LCC_IDX_LEVEL_TWO, 2'h0};
  localparam logic [11:0] LCC_ADDR_CTL_TWO   = {2'h0, LCC_IDX_CTL_TWO, 2'h0};

  // Decode hit positions
  localparam int LCC_HIT_LEVEL_ONE = 0;
  localparam int LCC_HIT_CTL_ONE   = 1;
  localparam int LCC_HIT_LEVEL_TWO = 2;
  localparam int LCC_HIT_CTL_TWO   = 3;

  // ==========================================================
  // Control register fields
  localparam int LCC_EN_BIT = 7;
  localparam int LCC_OE_HI  = 5;
  localparam int LCC_OE_LO  = 4;
  localparam int LCC_UP_HI  = 3;
  localparam int LCC_UP_LO  = 2;
  localparam int LCC_LO_BIT = 0;

  localparam logic [7:0] LCC_CTL_MASK_ONE = 8'hBD;
  localparam logic [7:0] LCC_CTL_MASK_TWO = 8'h8D;
  localparam logic [7:0] LCC_CTL_RESET    = 8'h00;
  localparam logic [7:0] LCC_LEVEL_RESET  = 8'h00;

  // ==========================================================
  // Codes
  localparam logic [1:0] LCC_OE_PIN_TWO  = 2'h2;
  localparam logic [1:0] LCC_OE_PIN_ZERO = 2'h1;
  localparam logic [1:0] LCC_UP_SUPPLY   = 2'h0;
  localparam logic [1:0] LCC_UP_EXT      = 2'h1;
  localparam logic [1:0] LCC_UP_FIXED    = 2'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       en;
    logic [1:0] oe;
    logic [1:0] upper;
    logic       lower;
    logic [7:0] code;
  } lcc_cfg_t;

  typedef struct packed {
    logic       active;
    logic       ref_on;
    logic       sw_supply;
    logic       sw_ext;
    logic       sw_fixed;
    logic       sw_lower_ext;
    logic       sw_lower_gnd;
    logic [7:0] tap;
    logic       pin_zero;
    logic       pin_two;
  } lcc_out_t;

endpackage

// >>> verilog/lcc_apb_slave.sv
// APB address decode and handshake for the converter registers.
// Assumes a standard APB master on pclk; answers with no wait state.
`timescale 1ns/100ps
module lcc_apb_slave
  import lcc_pkg::*;
(
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [LCC_AW-1:0] paddr,
  output logic                   pready,
  output logic                   pslverr,
  output logic [3:0]             hit,
  output logic                   wr_stb,
  output logic                   rd_setup
);

  // ==========================================================
  // Address decode
  always_comb
  begin
    hit                    = 4'h0;
    hit[LCC_HIT_LEVEL_ONE] = (paddr == LCC_ADDR_LEVEL_ONE);
    hit[LCC_HIT_CTL_ONE]   = (paddr == LCC_ADDR_CTL_ONE);
    hit[LCC_HIT_LEVEL_TWO] = (paddr == LCC_ADDR_LEVEL_TWO);
    hit[LCC_HIT_CTL_TWO]   = (paddr == LCC_ADDR_CTL_TWO);
  end

  // ==========================================================
  // Handshake
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(|hit);
  assign wr_stb   = psel & penable & pwrite & (|hit);
  assign rd_setup = psel & ~penable & ~pwrite;

endmodule

// >>> verilog/lcc_channel.sv
// One converter instance: turns its settings into ladder, switch and pin controls.
// Assumes settings come from registers on the same clock.
`timescale 1ns/100ps
module lcc_channel
  import lcc_pkg::*;
#(
  parameter bit HAS_PINS = 1'b1
)
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire lcc_cfg_t cfg,
  input  wire logic     sleep_active,
  output lcc_out_t      out_q
);

  lcc_out_t out_d;
  logic     ref_live;

  // ==========================================================
  // Next control state
  always_comb
  begin
    out_d        = '0;
    ref_live     = cfg.en & ~sleep_active;
    out_d.active = cfg.en;
    out_d.ref_on = ref_live;
    if (ref_live)
    begin
      out_d.sw_supply    = (cfg.upper == LCC_UP_SUPPLY);
      out_d.sw_ext       = (cfg.upper == LCC_UP_EXT);
      out_d.sw_fixed     = (cfg.upper == LCC_UP_FIXED);
      out_d.sw_lower_ext = cfg.lower;
      out_d.sw_lower_gnd = ~cfg.lower;
    end
    if (cfg.en)
    begin
      out_d.tap = cfg.code;
    end
    if (HAS_PINS && cfg.en)
    begin
      case (cfg.oe)
        LCC_OE_PIN_TWO:  out_d.pin_two  = 1'b1;
        LCC_OE_PIN_ZERO: out_d.pin_zero = 1'b1;
        default:         out_d.pin_zero = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

endmodule

// >>> verilog/lcc_top.sv
// Top of the ladder converter control block: APB registers and two converter instances.
// Assumes an APB master on pclk (25 MHz) and a sleep level from the power manager on pclk.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module lcc_top
  import lcc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [LCC_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sleep_active,
  output lcc_out_t               out_one,
  output lcc_out_t               out_two
);

  logic [7:0]  level_one_q;
  logic [7:0]  ctl_one_q;
  logic [7:0]  level_two_q;
  logic [7:0]  ctl_two_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic [3:0]  hit;
  logic        wr_stb;
  logic        rd_setup;
  logic        wr_lane;
  lcc_cfg_t    cfg_one;
  lcc_cfg_t    cfg_two;

  // ==========================================================
  // Bus slave
  lcc_apb_slave u_apb
  (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .hit      (hit),
    .wr_stb   (wr_stb),
    .rd_setup (rd_setup)
  );

  // Only the low byte lane carries register data
  assign wr_lane = wr_stb & pstrb[0];

  // ==========================================================
  // Level code registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_one_q <= LCC_LEVEL_RESET;
    end
    else if (wr_lane && hit[LCC_HIT_LEVEL_ONE])
    begin
      level_one_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_two_q <= LCC_LEVEL_RESET;
    end
    else if (wr_lane && hit[LCC_HIT_LEVEL_TWO])
    begin
      level_two_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Control registers; only presetn clears them, sleep and wake do not
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_one_q <= LCC_CTL_RESET;
    end
    else if (wr_lane && hit[LCC_HIT_CTL_ONE])
    begin
      ctl_one_q <= pwdata[7:0] & LCC_CTL_MASK_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_two_q <= LCC_CTL_RESET;
    end
    else if (wr_lane && hit[LCC_HIT_CTL_TWO])
    begin
      ctl_two_q <= pwdata[7:0] & LCC_CTL_MASK_TWO;
    end
  end

  // ==========================================================
  // Read data, captured in the setup phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit[LCC_HIT_LEVEL_ONE]: rd_mux[7:0] = level_one_q;
      hit[LCC_HIT_CTL_ONE]:   rd_mux[7:0] = ctl_one_q;
      hit[LCC_HIT_LEVEL_TWO]: rd_mux[7:0] = level_two_q;
      hit[LCC_HIT_CTL_TWO]:   rd_mux[7:0] = ctl_two_q;
      default:                rd_mux      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

  // ==========================================================
  // Converter instances
  always_comb
  begin
    cfg_one       = '0;
    cfg_one.en    = ctl_one_q[LCC_EN_BIT];
    cfg_one.oe    = ctl_one_q[LCC_OE_HI:LCC_OE_LO];
    cfg_one.upper = ctl_one_q[LCC_UP_HI:LCC_UP_LO];
    cfg_one.lower = ctl_one_q[LCC_LO_BIT];
    cfg_one.code  = level_one_q;
    cfg_two       = '0;
    cfg_two.en    = ctl_two_q[LCC_EN_BIT];
    cfg_two.upper = ctl_two_q[LCC_UP_HI:LCC_UP_LO];
    cfg_two.lower = ctl_two_q[LCC_LO_BIT];
    cfg_two.code  = level_two_q;
  end

  lcc_channel #(.HAS_PINS(1'b1)) u_one
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg_one),
    .sleep_active (sleep_active),
    .out_q        (out_one)
  );

  lcc_channel #(.HAS_PINS(1'b0)) u_two
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg_two),
    .sleep_active (sleep_active),
    .out_q        (out_two)
  );

  // ==========================================================
  // Checks
  chk_enable_gates: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctl_one_q[LCC_EN_BIT] |=> !out_one.active && !out_one.ref_on && out_one.tap == 8'h00
  ) else $error("converter one active while disabled");

  chk_pin_route_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && ctl_one_q[LCC_OE_HI:LCC_OE_LO] == LCC_OE_PIN_TWO
    |=> out_one.pin_two && !out_one.pin_zero
  ) else $error("pin two not routed for code 10");

  chk_pin_route_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && ctl_one_q[LCC_OE_HI:LCC_OE_LO] == LCC_OE_PIN_ZERO
    |=> out_one.pin_zero && !out_one.pin_two
  ) else $error("pin zero not routed for code 01");

  chk_pin_one_hot: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(out_one.pin_zero && out_one.pin_two)
  ) else $error("both output pins connected");

  chk_upper_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && !sleep_active && ctl_one_q[LCC_UP_HI:LCC_UP_LO] == LCC_UP_FIXED
    |=> out_one.sw_fixed && !out_one.sw_supply && !out_one.sw_ext
  ) else $error("fixed buffer not selected for code 10");

  chk_lower_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_two_q[LCC_EN_BIT] && !sleep_active
    |=> out_two.sw_lower_ext == $past(ctl_two_q[LCC_LO_BIT]) && out_two.sw_lower_gnd != out_two.sw_lower_ext
  ) else $error("lower reference switch wrong");

  chk_tap_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lane && hit[LCC_HIT_LEVEL_ONE] && ctl_one_q[LCC_EN_BIT] ##1 ctl_one_q[LCC_EN_BIT]
    |=> out_one.tap == $past(pwdata[7:0], 2)
  ) else $error("ladder tap does not follow level code");

  chk_reset_outputs: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !out_one.active && !out_one.pin_zero && !out_one.pin_two && !out_two.active
  ) else $error("outputs not cleared by reset");

  chk_reset_regs: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> level_one_q == 8'h00 && ctl_one_q == 8'h00 && level_two_q == 8'h00 && ctl_two_q == 8'h00
  ) else $error("registers not cleared by reset");

  chk_sleep_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    sleep_active && !wr_stb ##1 !sleep_active
    |-> $stable(ctl_one_q) && $stable(level_one_q) && $stable(ctl_two_q) && $stable(level_two_q)
  ) else $error("registers changed across wake");

  chk_sleep_ref_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    sleep_active |=> !out_one.ref_on && !out_two.ref_on && !out_one.sw_supply && !out_two.sw_ext
  ) else $error("reference on during sleep");

  chk_two_no_pins: assert property (
    @(posedge pclk) disable iff (!presetn)
    !out_two.pin_zero && !out_two.pin_two && ctl_two_q[LCC_OE_HI:LCC_OE_LO] == 2'h0
  ) else $error("second instance drives a pin");

  chk_decode_ctl: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lane && paddr == LCC_ADDR_CTL_ONE |=> ctl_one_q == ($past(pwdata[7:0]) & LCC_CTL_MASK_ONE)
  ) else $error("control one not written at its address");

  chk_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && hit == 4'h0 |-> pslverr && pready
  ) else $error("unmapped access not flagged");

  chk_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctl_one_q & ~LCC_CTL_MASK_ONE) == 8'h00 && (ctl_two_q & ~LCC_CTL_MASK_TWO) == 8'h00
  ) else $error("unimplemented control bit set");

  chk_pin_off_codes: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_OE_HI] == ctl_one_q[LCC_OE_LO] |=> !out_one.pin_zero && !out_one.pin_two
  ) else $error("pin connected for a disconnect code");

  chk_pins_need_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctl_one_q[LCC_EN_BIT] |=> !out_one.pin_zero && !out_one.pin_two
  ) else $error("pin connected while converter one disabled");

  chk_upper_supply: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && !sleep_active && ctl_one_q[LCC_UP_HI:LCC_UP_LO] == LCC_UP_SUPPLY
    |=> out_one.sw_supply && !out_one.sw_ext && !out_one.sw_fixed
  ) else $error("supply not selected for code 00");

  chk_upper_ext: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_two_q[LCC_EN_BIT] && !sleep_active && ctl_two_q[LCC_UP_HI:LCC_UP_LO] == LCC_UP_EXT
    |=> out_two.sw_ext && !out_two.sw_supply && !out_two.sw_fixed
  ) else $error("external reference not selected for code 01");

  chk_switch_one_hot: assert property (
    @(posedge pclk) disable iff (!presetn)
    $onehot0({out_one.sw_supply, out_one.sw_ext, out_one.sw_fixed}) && !(out_one.sw_lower_ext && out_one.sw_lower_gnd)
    && $onehot0({out_two.sw_supply, out_two.sw_ext, out_two.sw_fixed}) && !(out_two.sw_lower_ext && out_two.sw_lower_gnd)
  ) else $error("two reference switches closed at once");

  chk_two_en_gates: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctl_two_q[LCC_EN_BIT] |=> !out_two.active && !out_two.ref_on && out_two.tap == 8'h00
  ) else $error("converter two active while disabled");

  chk_tap_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_two_q[LCC_EN_BIT] |=> out_two.tap == $past(level_two_q)
  ) else $error("ladder tap two does not follow level code");

  chk_wake_ref_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && !sleep_active |=> out_one.ref_on && out_one.active
  ) else $error("reference off while awake and enabled");

  chk_lower_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctl_one_q[LCC_EN_BIT] && !sleep_active
    |=> out_one.sw_lower_ext == $past(ctl_one_q[LCC_LO_BIT]) && out_one.sw_lower_gnd == !$past(ctl_one_q[LCC_LO_BIT])
  ) else $error("lower reference switch of converter one wrong");

  chk_decode_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lane && paddr == LCC_ADDR_LEVEL_TWO |=> level_two_q == $past(pwdata[7:0])
  ) else $error("level two not written at its address");

  chk_read_ctl_two: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && hit[LCC_HIT_CTL_TWO] |=> prdata == {24'h00_0000, $past(ctl_two_q)}
  ) else $error("control two read data wrong");

  chk_strobe_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_stb && !pstrb[0]
    |=> $stable(level_one_q) && $stable(ctl_one_q) && $stable(level_two_q) && $stable(ctl_two_q)
  ) else $error("write without low lane strobe changed a register");

endmodule

// >>> test/lcc_ladder_model.sv
// Far side of the converter: reference switches and resistor ladder.
// Assumes the switch struct from the block; levels in millivolts.
`timescale 1ns/100ps
module lcc_ladder_model
  import lcc_pkg::*;
#(
  parameter int VDD_MV = 3300,
  parameter int VRP_MV = 2048,
  parameter int FVR_MV = 1024,
  parameter int VRN_MV = 256
)
(
  input  wire lcc_out_t ctl,
  output int            level_mv
);
  int hi_mv;
  int lo_mv;

  // ==========================================================
  // Ladder output
  always_comb
  begin
    hi_mv = ctl.sw_supply ? VDD_MV : ctl.sw_ext ? VRP_MV : ctl.sw_fixed ? FVR_MV : 0;
    lo_mv = ctl.sw_lower_ext ? VRN_MV : 0;
    level_mv = 0;
    if (ctl.active && ctl.ref_on)
      level_mv = lo_mv + (hi_mv - lo_mv) * int'(ctl.tap) / 256;
  end
endmodule

// >>> test/ladder_converter_ctrl_bench.sv
// Self-checking bench for the ladder converter control block.
// Assumes lcc_top with APB registers and the ladder model as far side.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end
module ladder_converter_ctrl_bench
  import lcc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        sleep_active = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  lcc_out_t    out_one;
  lcc_out_t    out_two;
  int          level_mv;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [31:0] rv;
  logic        re;
  logic [7:0]  c;

  lcc_top i_lcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
    .out_one(out_one), .out_two(out_two));

  lcc_ladder_model i_lcc_ladder_model (.ctl(out_one), .level_mv(level_mv));

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      end_sim();
    end
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 4'hF);
    `CHK(nm, {24'h0, e}, rv)
  endtask

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic note(input string n);
    $display("Test %s finished", n);
  endtask

  // Expected switch and pin state from register contents
  function automatic lcc_out_t exp_out(logic [7:0] k, logic [7:0] l, logic slp, logic pins);
    lcc_out_t o;
    logic     on;
    o = '0;
    on = k[LCC_EN_BIT] & ~slp;
    o.active = k[LCC_EN_BIT];
    o.ref_on = on;
    o.sw_supply = on && k[3:2] == LCC_UP_SUPPLY;
    o.sw_ext = on && k[3:2] == LCC_UP_EXT;
    o.sw_fixed = on && k[3:2] == LCC_UP_FIXED;
    o.sw_lower_ext = on & k[LCC_LO_BIT];
    o.sw_lower_gnd = on & ~k[LCC_LO_BIT];
    o.tap = k[LCC_EN_BIT] ? l : 8'h00;
    o.pin_zero = pins && k[LCC_EN_BIT] && k[5:4] == LCC_OE_PIN_ZERO;
    o.pin_two = pins && k[LCC_EN_BIT] && k[5:4] == LCC_OE_PIN_TWO;
    return o;
  endfunction

  task automatic chk_outs(input logic [7:0] c1, l1, c2, l2);
    `CHK("out_one", exp_out(c1, l1, sleep_active, 1'b1), out_one)
    `CHK("out_two", exp_out(c2, l2, sleep_active, 1'b0), out_two)
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_outs(8'h00, 8'h00, 8'h00, 8'h00);
    rd_chk("lvl1", LCC_ADDR_LEVEL_ONE, 8'h00);
    rd_chk("ctl1", LCC_ADDR_CTL_ONE, 8'h00);
    rd_chk("lvl2", LCC_ADDR_LEVEL_TWO, 8'h00);
    rd_chk("ctl2", LCC_ADDR_CTL_TWO, 8'h00);
    note("reset");
    wr(LCC_ADDR_LEVEL_ONE, 8'hFF);
    wr(LCC_ADDR_CTL_ONE, 8'hF7);
    wr(LCC_ADDR_LEVEL_TWO, 8'hFF);
    wr(LCC_ADDR_CTL_TWO, 8'hF7);
    rd_chk("lvl1", LCC_ADDR_LEVEL_ONE, 8'hFF);
    rd_chk("ctl1", LCC_ADDR_CTL_ONE, 8'hB5);
    rd_chk("lvl2", LCC_ADDR_LEVEL_TWO, 8'hFF);
    rd_chk("ctl2", LCC_ADDR_CTL_TWO, 8'h85);
    rd_chk("hole", 12'h1F8, 8'h00);
    `CHK("slverr", 1'b1, re)
    apb(1'b1, LCC_ADDR_LEVEL_ONE, 8'h12, 4'hE);
    rd_chk("strb", LCC_ADDR_LEVEL_ONE, 8'hFF);
    wr(LCC_ADDR_LEVEL_ONE, 8'h5A);
    wr(LCC_ADDR_LEVEL_TWO, 8'hA5);
    note("map");
    for (int k = 0; k < 4; k++)
    begin
      c = {2'b10, k[1:0], 4'h0};
      wr(LCC_ADDR_CTL_ONE, c);
      wr(LCC_ADDR_CTL_TWO, c);
      settle();
      chk_outs(c, 8'h5A, c, 8'hA5);
    end
    note("pins");
    for (int u = 0; u < 3; u++)
    begin
      for (int n = 0; n < 2; n++)
      begin
        c = {4'h8, u[1:0], 1'b0, n[0]};
        wr(LCC_ADDR_CTL_ONE, c);
        wr(LCC_ADDR_CTL_TWO, c);
        settle();
        chk_outs(c, 8'h5A, c, 8'hA5);
      end
    end
    note("refs");
    wr(LCC_ADDR_CTL_ONE, 8'h84);
    wr(LCC_ADDR_LEVEL_ONE, 8'h80);
    settle();
    `CHK("mv_a", 1024, level_mv)
    wr(LCC_ADDR_CTL_ONE, 8'h89);
    wr(LCC_ADDR_LEVEL_ONE, 8'h40);
    settle();
    `CHK("mv_b", 448, level_mv)
    wr(LCC_ADDR_CTL_ONE, 8'h24);
    wr(LCC_ADDR_CTL_TWO, 8'h05);
    settle();
    chk_outs(8'h24, 8'h40, 8'h05, 8'hA5);
    note("ladder");
    wr(LCC_ADDR_CTL_ONE, 8'hA8);
    wr(LCC_ADDR_CTL_TWO, 8'h89);
    @(posedge pclk);
    sleep_active <= 1'b1;
    settle();
    chk_outs(8'hA8, 8'h40, 8'h89, 8'hA5);
    @(posedge pclk);
    sleep_active <= 1'b0;
    settle();
    chk_outs(8'hA8, 8'h40, 8'h89, 8'hA5);
    rd_chk("ctl1", LCC_ADDR_CTL_ONE, 8'hA8);
    rd_chk("lvl1", LCC_ADDR_LEVEL_ONE, 8'h40);
    note("sleep");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk_outs(8'h00, 8'h00, 8'h00, 8'h00);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctl1", LCC_ADDR_CTL_ONE, 8'h00);
    rd_chk("lvl2", LCC_ADDR_LEVEL_TWO, 8'h00);
    note("rerun");
    end_sim();
  end

  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end
endmodule
